// ==== src/wxr_unit.sv ====
// Word xor, negate and rotate datapath driven by the scan sequencer
`timescale 1ns/1ps
module wxr_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic exec_stb,
  input wire logic drive_cond,
  input wire wxr_pkg::wxr_req_t req,
  input wire wxr_pkg::wxr_dword_t src1,
  input wire wxr_pkg::wxr_dword_t src2,
  input wire wxr_pkg::wxr_dword_t dst,
  output wxr_pkg::wxr_dword_t result_r,
  output logic wr_lo_r,
  output logic wr_hi_r,
  output logic carry_flag_r,
  output logic sign_r,
  output logic error_r
);
  import wxr_pkg::*;

  logic cond_prev_r;
  logic rise;
  logic fire;
  logic is_rot;
  logic is_thru;
  logic rot_left;
  logic count_bad;
  logic group_bad;
  logic invalid;
  logic do_write;
  logic count_zero;
  logic [DWORD_W-1:0] d_full;
  logic [DWORD_W-1:0] xor_full;
  logic [DWORD_W-1:0] neg_full;
  logic [WORD_W-1:0] neg_word;
  logic [WORD_W-1:0] rot16;
  logic [WORD_W:0] rot17;
  logic [DWORD_W-1:0] rot32;
  logic [DWORD_W:0] rot33;
  logic [DWORD_W-1:0] res_full;
  logic carry_nxt;
  wxr_dword_t result_nxt;
  logic sign_nxt;

  // Pulse form needs an off-to-on edge seen across scans, so history moves only on the strobe
  assign rise = drive_cond & ~cond_prev_r;
  assign fire = exec_stb & (req.pulse ? rise : drive_cond);

  assign is_rot = (req.op != OP_WORD_EXCLUSIVE_OR) && (req.op != OP_TWOS_COMPLEMENT_NEGATE);
  assign is_thru = (req.op == OP_ROTATE_RIGHT_THROUGH_CARRY) || (req.op == OP_ROTATE_LEFT_THROUGH_CARRY);
  assign rot_left = (req.op == OP_ROTATE_LEFT) || (req.op == OP_ROTATE_LEFT_THROUGH_CARRY);
  assign count_zero = (req.count == COUNT_ZERO);
  assign count_bad = req.dword ? (req.count > MAX_COUNT_DWORD) : (req.count > MAX_COUNT_WORD);
  assign group_bad = req.group_dst &&
                     (req.group_digits != (req.dword ? GROUP_DIGITS_DWORD : GROUP_DIGITS_WORD));
  assign invalid = is_rot & (count_bad | group_bad);
  assign do_write = fire & ~invalid;

  // Low half always lives in the lower register of the pair
  assign d_full = {dst.hi, dst.lo};
  assign xor_full = {src1.hi, src1.lo} ^ {src2.hi, src2.lo};
  assign neg_full = ~d_full + NEG_ADD_DWORD;
  // Most negative word wraps onto itself; no overflow flag exists to raise
  assign neg_word = ~dst.lo + NEG_ADD_WORD;

  wxr_rotator #(.W(WORD_W)) u_rot16 (
    .value(dst.lo),
    .count(req.count),
    .left(rot_left),
    .result(rot16)
  );

  wxr_rotator #(.W(WORD_W + 1)) u_rot17 (
    .value({carry_flag_r, dst.lo}),
    .count(req.count),
    .left(rot_left),
    .result(rot17)
  );

  wxr_rotator #(.W(DWORD_W)) u_rot32 (
    .value(d_full),
    .count(req.count),
    .left(rot_left),
    .result(rot32)
  );

  wxr_rotator #(.W(DWORD_W + 1)) u_rot33 (
    .value({carry_flag_r, d_full}),
    .count(req.count),
    .left(rot_left),
    .result(rot33)
  );

  always_comb begin
    res_full = d_full;
    carry_nxt = carry_flag_r;
    case (req.op)
      OP_WORD_EXCLUSIVE_OR: begin
        res_full = xor_full;
      end
      OP_TWOS_COMPLEMENT_NEGATE: begin
        res_full = req.dword ? neg_full : {dst.hi, neg_word};
      end
      OP_ROTATE_RIGHT, OP_ROTATE_LEFT: begin
        if (req.dword) begin
          res_full = rot32;
          if (!count_zero) begin
            carry_nxt = rot_left ? rot32[0] : rot32[SIGN_DWORD];
          end
        end else begin
          res_full = {dst.hi, rot16};
          if (!count_zero) begin
            carry_nxt = rot_left ? rot16[0] : rot16[SIGN_WORD];
          end
        end
      end
      OP_ROTATE_RIGHT_THROUGH_CARRY, OP_ROTATE_LEFT_THROUGH_CARRY: begin
        // Carry sits just above the operand in the chain
        if (req.dword) begin
          res_full = rot33[DWORD_W-1:0];
          carry_nxt = rot33[DWORD_W];
        end else begin
          res_full = {dst.hi, rot17[WORD_W-1:0]};
          carry_nxt = rot17[WORD_W];
        end
      end
      default: begin
        res_full = d_full;
        carry_nxt = carry_flag_r;
      end
    endcase
  end

  assign result_nxt = {res_full[DWORD_W-1:WORD_W], res_full[WORD_W-1:0]};
  assign sign_nxt = req.dword ? res_full[SIGN_DWORD] : res_full[SIGN_WORD];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cond_prev_r <= 1'b0;
    end else if (exec_stb) begin
      cond_prev_r <= drive_cond;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_r <= '0;
      wr_lo_r <= 1'b0;
      wr_hi_r <= 1'b0;
      sign_r <= 1'b0;
    end else begin
      wr_lo_r <= do_write;
      wr_hi_r <= do_write & req.dword;
      if (do_write) begin
        result_r <= result_nxt;
        sign_r <= sign_nxt;
      end
    end
  end

  // An invalid rotate leaves both destination and carry untouched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      carry_flag_r <= 1'b0;
      error_r <= 1'b0;
    end else begin
      if (do_write && is_rot) begin
        carry_flag_r <= carry_nxt;
      end
      if (fire) begin
        error_r <= invalid;
      end
    end
  end

  a_xor_result: assert property (@(posedge clk) disable iff (sys_rst)
    (do_write && req.op == OP_WORD_EXCLUSIVE_OR && !req.dword) |=>
      (wr_lo_r && result_r.lo == ($past(src1.lo) ^ $past(src2.lo))))
    else $error("xor result wrong");

  a_neg_result: assert property (@(posedge clk) disable iff (sys_rst)
    (do_write && req.op == OP_TWOS_COMPLEMENT_NEGATE && req.dword) |=>
      ({result_r.hi, result_r.lo} + $past({dst.hi, dst.lo}) == 32'h0000_0000))
    else $error("negate sum not zero");

  a_neg_most_neg: assert property (@(posedge clk) disable iff (sys_rst)
    (do_write && req.op == OP_TWOS_COMPLEMENT_NEGATE && !req.dword && dst.lo == WORD_MOST_NEG) |=>
      (result_r.lo == WORD_MOST_NEG && sign_r))
    else $error("most negative not kept");

  a_pulse_once: assert property (@(posedge clk) disable iff (sys_rst)
    (exec_stb && req.pulse && drive_cond && cond_prev_r) |=> !wr_lo_r)
    else $error("pulse form repeated");

  a_cont_repeat: assert property (@(posedge clk) disable iff (sys_rst)
    (exec_stb && !req.pulse && drive_cond && !invalid) |=> wr_lo_r)
    else $error("continuous form skipped");

  a_count_limit: assert property (@(posedge clk) disable iff (sys_rst)
    (fire && is_rot && !req.dword && req.count > MAX_COUNT_WORD) |=> (error_r && !wr_lo_r && $stable(carry_flag_r)))
    else $error("oversized count accepted");

  a_rot_carry: assert property (@(posedge clk) disable iff (sys_rst)
    (do_write && req.op == OP_ROTATE_LEFT && !req.dword && !count_zero) |=> (carry_flag_r == result_r.lo[0]))
    else $error("rotate carry wrong");

  a_group_check: assert property (@(posedge clk) disable iff (sys_rst)
    (fire && is_rot && req.group_dst && req.dword && req.group_digits == GROUP_DIGITS_WORD) |=>
      (error_r && !wr_hi_r))
    else $error("bad group accepted");

  a_thru_chain: assert property (@(posedge clk) disable iff (sys_rst)
    (do_write && req.op == OP_ROTATE_RIGHT_THROUGH_CARRY && !req.dword && req.count == 6'h01) |=>
      (carry_flag_r == $past(dst.lo[0]) && result_r.lo[SIGN_WORD] == $past(carry_flag_r)))
    else $error("through carry chain wrong");

  a_sign_bit: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(wr_hi_r) |-> (sign_r == result_r.hi[SIGN_WORD]))
    else $error("sign bit wrong");

  a_dword_pair: assert property (@(posedge clk) disable iff (sys_rst)
    (do_write && req.op == OP_WORD_EXCLUSIVE_OR && req.dword) |=>
      (wr_hi_r && result_r.hi == ($past(src1.hi) ^ $past(src2.hi))))
    else $error("pair high half wrong");

endmodule // wxr_unit

// ==== include/wxr_pkg.sv ====
// Shared types and constants for the word xor / negate / rotate unit
package wxr_pkg;

  localparam int WORD_W = 16;
  localparam int DWORD_W = 32;
  localparam int COUNT_W = 6;
  localparam int DIGITS_W = 4;

  localparam logic [COUNT_W-1:0] MAX_COUNT_WORD = 6'h10;
  localparam logic [COUNT_W-1:0] MAX_COUNT_DWORD = 6'h20;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 6'h00;
  localparam logic [DIGITS_W-1:0] GROUP_DIGITS_WORD = 4'h4;
  localparam logic [DIGITS_W-1:0] GROUP_DIGITS_DWORD = 4'h8;
  localparam logic [WORD_W-1:0] NEG_ADD_WORD = 16'h0001;
  localparam logic [DWORD_W-1:0] NEG_ADD_DWORD = 32'h0000_0001;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_MOST_NEG = 16'h8000;
  localparam int SIGN_WORD = 15;
  localparam int SIGN_DWORD = 31;

  typedef enum logic [2:0] {
    OP_WORD_EXCLUSIVE_OR,
    OP_TWOS_COMPLEMENT_NEGATE,
    OP_ROTATE_RIGHT,
    OP_ROTATE_LEFT,
    OP_ROTATE_RIGHT_THROUGH_CARRY,
    OP_ROTATE_LEFT_THROUGH_CARRY
  } wxr_op_t;

  typedef struct packed {
    logic [WORD_W-1:0] hi;
    logic [WORD_W-1:0] lo;
  } wxr_dword_t;

  typedef struct packed {
    wxr_op_t op;
    logic dword;
    logic pulse;
    logic group_dst;
    logic [DIGITS_W-1:0] group_digits;
    logic [COUNT_W-1:0] count;
  } wxr_req_t;

endpackage

// ==== src/wxr_rotator.sv ====
// Barrel rotator of configurable width
`timescale 1ns/1ps
module wxr_rotator #(
  parameter int W = 16
) (
  input wire logic [W-1:0] value,
  input wire logic [wxr_pkg::COUNT_W-1:0] count,
  input wire logic left,
  output logic [W-1:0] result
);
  import wxr_pkg::*;

  logic [2*W-1:0] dbl;
  logic [2*W-1:0] shl;
  logic [2*W-1:0] shr;

  // Doubling the word makes a plain shift act as a wrap-around rotate
  assign dbl = {value, value};
  assign shl = dbl << count;
  assign shr = dbl >> count;
  assign result = left ? shl[2*W-1:W] : shr[W-1:0];

endmodule // wxr_rotator

// ==== verif/word_xor_negate_rotate_unit_tb.sv ====
// Self-checking bench for the word xor / negate / rotate unit
`timescale 1ns/1ps
module word_xor_negate_rotate_unit_tb;
  import wxr_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic exec_stb = 1'b0;
  logic drive_cond = 1'b0;
  wxr_req_t req = '0;
  wxr_dword_t src1 = '0;
  wxr_dword_t src2 = '0;
  wxr_dword_t dst = '0;
  wxr_dword_t result_r;
  logic wr_lo_r, wr_hi_r, carry_flag_r, sign_r, error_r;
  int errors = 0;
  int tests_run = 0;
  logic [31:0] e_res = '0;
  logic e_lo = 1'b0, e_hi = 1'b0, e_c = 1'b0, e_s = 1'b0, e_e = 1'b0, prev = 1'b0;

  always #5 clk = ~clk;

  wxr_unit dut (.clk(clk), .sys_rst(sys_rst), .exec_stb(exec_stb), .drive_cond(drive_cond), .req(req),
    .src1(src1), .src2(src2), .dst(dst), .result_r(result_r), .wr_lo_r(wr_lo_r), .wr_hi_r(wr_hi_r),
    .carry_flag_r(carry_flag_r), .sign_r(sign_r), .error_r(error_r));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One step per rotate position keeps the model obviously right, at the cost of speed
  function automatic longint rotn(longint v, int w, int n, bit left);
    longint m;
    m = (64'h1 << w) - 1;
    for (int k = 0; k < n; k++) begin
      if (left) v = ((v << 1) | ((v >> (w - 1)) & 1)) & m;
      else v = (v >> 1) | ((v & 1) << (w - 1));
    end
    return v;
  endfunction

  task automatic model();
    longint op, r, m, v;
    int w, n;
    bit fire, ok, left, thru;
    w = req.dword ? 32 : 16;
    n = int'(req.count);
    m = (64'h1 << w) - 1;
    fire = drive_cond && (!req.pulse || !prev);
    prev = drive_cond;
    e_lo = 1'b0;
    e_hi = 1'b0;
    if (!fire) return;
    op = req.dword ? longint'(dst) : longint'(dst.lo);
    ok = 1'b1;
    left = (req.op == OP_ROTATE_LEFT) || (req.op == OP_ROTATE_LEFT_THROUGH_CARRY);
    thru = (req.op == OP_ROTATE_RIGHT_THROUGH_CARRY) || (req.op == OP_ROTATE_LEFT_THROUGH_CARRY);
    r = op;
    if (req.op == OP_WORD_EXCLUSIVE_OR) r = (longint'(src1) ^ longint'(src2)) & m;
    else if (req.op == OP_TWOS_COMPLEMENT_NEGATE) r = ((~op) + 1) & m;
    else begin
      ok = (n <= w) && (!req.group_dst || req.group_digits == (req.dword ? 4'h8 : 4'h4));
      if (ok && thru) begin
        v = rotn((longint'(e_c) << w) | op, w + 1, n, left);
        r = v & m;
        e_c = v[w];
      end else if (ok) begin
        r = rotn(op, w, n, left);
        if (n > 0) e_c = left ? r[0] : r[w - 1];
      end
    end
    e_e = !ok;
    if (!ok) return;
    e_lo = 1'b1;
    e_hi = req.dword;
    e_res = req.dword ? 32'(r) : {dst.hi, 16'(r)};
    // Word xor still presents the upper source halves combined, though nothing writes them
    if (req.op == OP_WORD_EXCLUSIVE_OR) e_res[31:16] = src1.hi ^ src2.hi;
    e_s = r[w - 1];
  endtask

  task automatic step();
    if (sys_rst) begin
      {e_res, e_lo, e_hi, e_c, e_s, e_e, prev} = '0;
    end else if (exec_stb) model();
    else {e_lo, e_hi} = 2'b00;
    @(posedge clk);
    #1;
    check("result", result_r, e_res);
    check("wr_lo", 32'(wr_lo_r), 32'(e_lo));
    check("wr_hi", 32'(wr_hi_r), 32'(e_hi));
    check("carry", 32'(carry_flag_r), 32'(e_c));
    check("sign", 32'(sign_r), 32'(e_s));
    check("error", 32'(error_r), 32'(e_e));
  endtask

  task automatic issue(input wxr_op_t o, input bit dw, input bit pl, input bit cd, input int cnt, input logic [31:0] d);
    exec_stb = 1'b1;
    drive_cond = cd;
    req = '{op: o, dword: dw, pulse: pl, group_dst: 1'b0, group_digits: 4'h4, count: 6'(cnt)};
    dst = d;
    step();
  endtask

  initial begin
    #200000;
    errors++;
    complete_run();
  end

  initial begin
    void'($urandom(32'hc27a));
    repeat (20) step();
    sys_rst = 1'b0;
    issue(OP_ROTATE_LEFT, 0, 0, 1, 4, 32'h1234_8001);
    issue(OP_TWOS_COMPLEMENT_NEGATE, 0, 0, 1, 0, 32'h0000_8000);
    issue(OP_TWOS_COMPLEMENT_NEGATE, 0, 0, 1, 0, 32'h0000_0005);
    issue(OP_TWOS_COMPLEMENT_NEGATE, 0, 0, 1, 0, 32'h0000_0005);
    // Condition off first, so the pulse pair sees a real off-to-on edge
    issue(OP_ROTATE_RIGHT, 0, 1, 0, 3, 32'h0000_0007);
    issue(OP_ROTATE_RIGHT, 0, 1, 1, 3, 32'h0000_0007);
    issue(OP_ROTATE_RIGHT, 0, 1, 1, 3, 32'h0000_0007);
    issue(OP_ROTATE_RIGHT_THROUGH_CARRY, 0, 0, 1, 16, 32'h0000_a5a5);
    issue(OP_ROTATE_LEFT_THROUGH_CARRY, 0, 0, 1, 17, 32'h0000_a5a5);
    issue(OP_ROTATE_LEFT, 1, 0, 1, 32, 32'h8000_0001);
    issue(OP_ROTATE_RIGHT, 1, 0, 1, 33, 32'h8000_0001);
    for (int i = 0; i < 3000; i++) begin
      exec_stb = ($urandom_range(0, 4) != 0);
      drive_cond = ($urandom_range(0, 2) != 0);
      req.op = wxr_op_t'($urandom_range(0, 5));
      req.dword = $urandom_range(0, 1);
      req.pulse = $urandom_range(0, 1);
      req.group_dst = ($urandom_range(0, 3) == 0);
      req.group_digits = ($urandom_range(0, 2) == 0) ? 4'($urandom) : (req.dword ? 4'h8 : 4'h4);
      req.count = 6'($urandom_range(0, 34));
      src1 = $urandom;
      src2 = $urandom;
      dst = $urandom;
      if (i == 1500) sys_rst = 1'b1;
      if (i == 1503) sys_rst = 1'b0;
      step();
    end
    complete_run();
  end
endmodule // word_xor_negate_rotate_unit_tb
